// ===== logic/rmbs_top.sv
`timescale 1ns/10ps
// What this block does
// - in 4K arrays each of the first twelve chips takes data input from its own bus line
// - chips beyond the twelve address lines take data from spare bus lines; the 4K wiring here takes bus lines 0 to 3 instead
// - each chip output stays separate, through its own driver stage
// - in 8K arrays same-bit chips may share data inputs and outputs
// - select array when bank lines equal jumpers and refresh line low
// - enable array access only while memory cycle strobe asserted
// - during refresh select array on strobe regardless of bank lines
// - during refresh drive every chip select feed high
// - inhibit line low keeps output enable inactive, outputs off bus
// - overbar signals active low, others active high
module rmbs_top
	import rmbs_pkg::*;
#(
	parameter int CHIPS     = rmbs_pkg::BUS_W,
	parameter bit WIDE_8K   = 1'b0
)(
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic [rmbs_pkg::BUS_W-1:0] mem_bus_in,
	input  wire logic [rmbs_pkg::BANK_W-1:0] bank_address_lines,
	input  wire logic                       refresh_select_line,
	input  wire logic                       memory_cycle_strobe_n,
	input  wire logic                       ram_inhibit_line_n,
	input  wire logic                       bank_jumper_one,
	input  wire logic                       bank_jumper_two,
	input  wire logic                       bank_jumper_three,
	input  wire logic [CHIPS-1:0]           chip_data_out,
	output logic [CHIPS-1:0]                chip_data_in,
	output logic                            refresh_chip_select_feed,
	output logic                            array_strobe_n,
	output logic                            ram_output_enable_n,
	output logic [rmbs_pkg::BUS_W-1:0]      mem_bus_out,
	output logic [rmbs_pkg::BUS_W-1:0]      mem_bus_oe_n,
	output logic [2:0]                      state_out
);
	import rmbs_pkg::*;

	// two-stage synchronisers for every pin input
	logic [BUS_W-1:0]  bus_s1_r, bus_s2_r;
	logic [BANK_W-1:0] bank_s1_r, bank_s2_r;
	logic [BANK_W-1:0] jmp_s1_r, jmp_s2_r;
	logic [CHIPS-1:0]  dout_s1_r, dout_s2_r;
	logic              ref_s1_r, ref_s2_r;
	logic              stb_s1_r, stb_s2_r;
	logic              inh_s1_r, inh_s2_r;
	rmbs_state_t       state_r, state_nxt;
	rmbs_sel_if        sel ();
	logic              strobe_active;
	logic              inhibit_active;
	logic [CHIPS-1:0]  din_nxt;
	logic [BUS_W-1:0]  oe_nxt;
	logic              drive_on;

	// bus lines, sampled for the chip data inputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_s1_r <= '0;
			bus_s2_r <= '0;
		end else begin
			bus_s1_r <= mem_bus_in;
			bus_s2_r <= bus_s1_r;
		end
	end

	// bank address lines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bank_s1_r <= '0;
			bank_s2_r <= '0;
		end else begin
			bank_s1_r <= bank_address_lines;
			bank_s2_r <= bank_s1_r;
		end
	end

	// bank jumpers, static but still pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			jmp_s1_r <= '0;
			jmp_s2_r <= '0;
		end else begin
			jmp_s1_r <= {bank_jumper_three, bank_jumper_two, bank_jumper_one};
			jmp_s2_r <= jmp_s1_r;
		end
	end

	// chip data outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dout_s1_r <= '0;
			dout_s2_r <= '0;
		end else begin
			dout_s1_r <= chip_data_out;
			dout_s2_r <= dout_s1_r;
		end
	end

	// refresh select, resets to the non-refresh level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ref_s1_r <= ~REFRESH_ON;
			ref_s2_r <= ~REFRESH_ON;
		end else begin
			ref_s1_r <= refresh_select_line;
			ref_s2_r <= ref_s1_r;
		end
	end

	// cycle strobe, resets inactive so no false cycle follows reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stb_s1_r <= ~STROBE_ON;
			stb_s2_r <= ~STROBE_ON;
		end else begin
			stb_s1_r <= memory_cycle_strobe_n;
			stb_s2_r <= stb_s1_r;
		end
	end

	// inhibit line, resets released
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			inh_s1_r <= ~INHIBIT_ON;
			inh_s2_r <= ~INHIBIT_ON;
		end else begin
			inh_s1_r <= ram_inhibit_line_n;
			inh_s2_r <= inh_s1_r;
		end
	end

	assign strobe_active  = (stb_s2_r == STROBE_ON);
	assign inhibit_active = (inh_s2_r == INHIBIT_ON);

	// decode sees synchronised lines only, so pin skew cannot strobe the array
	// bank decode
	rmbs_decode u_decode (
		.bank_lines    (bank_s2_r),
		.jumpers       (jmp_s2_r),
		.refresh_line  (ref_s2_r),
		.strobe_active (strobe_active),
		.sel           (sel.decoder)
	);

	// cycle state: idle, access or refresh
	always_comb begin
		case (1'b1)
			sel.refresh_sel: state_nxt = RMBS_REFRESH;
			sel.access_sel:  state_nxt = RMBS_ACCESS;
			default:         state_nxt = RMBS_IDLE;
		endcase
	end

	// cycle state register
	always_ff @(posedge clk) begin
		if (sys_rst)
			state_r <= RMBS_IDLE;
		else
			state_r <= state_nxt;
	end

	// data input wiring per chip
	// bits past the address lines reuse bus lines 0 to 3 unless WIDE_8K
	generate
		for (genvar i = 0; i < CHIPS; i++) begin : g_din
			if (i < ADDR_W || WIDE_8K) begin : g_addr
				assign din_nxt[i] = bus_s2_r[i % BUS_W];
			end else begin : g_spare
				assign din_nxt[i] = bus_s2_r[(32'(SPARE_LINE_BASE) + i - ADDR_W) % BUS_W];
			end
		end
	endgenerate

	// chip inputs, strobe and refresh chip select
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chip_data_in             <= '0;
			refresh_chip_select_feed <= 1'b0;
			array_strobe_n           <= 1'b1;
		end else begin
			chip_data_in <= din_nxt;
			refresh_chip_select_feed <= (state_nxt == RMBS_REFRESH);
			array_strobe_n <= !(state_nxt != RMBS_IDLE);
		end
	end

	// enable condition shared by the output stage
	// inhibit blocks enable
	assign drive_on = (state_nxt == RMBS_ACCESS) && !inhibit_active;

	// open-drain driver per bus line, discharges zeros only
	generate
		for (genvar b = 0; b < BUS_W; b++) begin : g_drv
			assign oe_nxt[b] = !(drive_on && !dout_s2_r[b % CHIPS]);
		end
	endgenerate

	// output stage towards memory bus
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ram_output_enable_n <= 1'b1;
			mem_bus_out         <= '0;
			mem_bus_oe_n        <= '1;
		end else begin
			ram_output_enable_n <= !drive_on;
			mem_bus_out         <= '0;
			mem_bus_oe_n        <= oe_nxt;
		end
	end

	// state visible for debug, straight from the state register
	assign state_out = state_r;
endmodule // rmbs_top

// ===== logic/rmbs_pkg.sv
package rmbs_pkg;
	// bus and array geometry
	localparam int BUS_W     = 16;
	localparam int BANK_W    = 3;
	localparam int ADDR_W    = 12;
	// memory cycle strobe and inhibit are active low on the pins
	localparam logic STROBE_ON  = 1'b0;
	localparam logic INHIBIT_ON = 1'b0;
	// refresh select high marks a refresh cycle
	localparam logic REFRESH_ON = 1'b1;
	// array data input source per bit: bits past the address lines reuse bus lines from line 0 up
	localparam logic [3:0] SPARE_LINE_BASE = 4'h0;
	typedef enum logic [2:0] {
		RMBS_IDLE    = 3'b001,
		RMBS_ACCESS  = 3'b010,
		RMBS_REFRESH = 3'b100
	} rmbs_state_t;
endpackage

// ===== logic/rmbs_sel_if.sv
`timescale 1ns/10ps
// decoded selection between the decoder and the output stage
interface rmbs_sel_if;
	logic access_sel;
	logic refresh_sel;
	modport decoder (output access_sel, output refresh_sel);
	modport user    (input access_sel, input refresh_sel);
endinterface

// ===== logic/rmbs_decode.sv
`timescale 1ns/10ps
// bank compare against jumpers, combinational on synchronised lines
module rmbs_decode
	import rmbs_pkg::*;
(
	input  wire logic [BANK_W-1:0] bank_lines,
	input  wire logic [BANK_W-1:0] jumpers,
	input  wire logic              refresh_line,
	input  wire logic              strobe_active,
	rmbs_sel_if.decoder            sel
);
	// match only outside refresh, refresh selects any bank
	always_comb begin
		sel.access_sel  = strobe_active && (refresh_line != REFRESH_ON) && (bank_lines == jumpers);
		sel.refresh_sel = strobe_active && (refresh_line == REFRESH_ON);
	end
endmodule // rmbs_decode

// ===== test/rmbs_asserts.sv
`timescale 1ns/10ps
module rmbs_asserts
	import rmbs_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic [BUS_W-1:0]  mem_bus_in,
	input wire logic [BANK_W-1:0] bank_address_lines,
	input wire logic              refresh_select_line,
	input wire logic              memory_cycle_strobe_n,
	input wire logic              ram_inhibit_line_n,
	input wire logic              bank_jumper_one,
	input wire logic              bank_jumper_two,
	input wire logic              bank_jumper_three,
	input wire logic [BUS_W-1:0]  chip_data_out,
	input wire logic [BUS_W-1:0]  chip_data_in,
	input wire logic              refresh_chip_select_feed,
	input wire logic              array_strobe_n,
	input wire logic              ram_output_enable_n,
	input wire logic [BUS_W-1:0]  mem_bus_oe_n,
	input wire logic [BUS_W-1:0]  mem_bus_out,
	input wire logic [2:0]        state_out
);
	logic [1:0] age_r;
	logic       ok, acc, rf, off;
	// settle count after reset
	always_ff @(posedge clk) begin
		if (sys_rst) age_r <= 2'h0;
		else if (!ok) age_r <= age_r + 2'h1;
	end
	// decoded cycle kinds
	assign ok = age_r == 2'h3;
	assign off = !refresh_select_line && bank_address_lines != {bank_jumper_three, bank_jumper_two, bank_jumper_one};
	assign acc = !memory_cycle_strobe_n && !refresh_select_line && !off;
	assign rf = !memory_cycle_strobe_n && refresh_select_line;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_acc; ok && $past(acc, 3) |-> !array_strobe_n && state_out == 3'h2; endproperty
	property p_rfs; ok && $past(rf, 3) |-> !array_strobe_n && ram_output_enable_n && state_out == 3'h4; endproperty
	property p_feed; ok && $past(rf, 3) |-> refresh_chip_select_feed; endproperty
	property p_stb; ok && $past(memory_cycle_strobe_n, 3) |-> array_strobe_n && ram_output_enable_n; endproperty
	property p_inh; ok && !$past(ram_inhibit_line_n, 3) |-> ram_output_enable_n && &mem_bus_oe_n; endproperty
	property p_off; ok && $past(off, 3) |-> array_strobe_n && &mem_bus_oe_n; endproperty
	property p_din; ok |-> chip_data_in == {$past(mem_bus_in[3:0], 3), $past(mem_bus_in[11:0], 3)}; endproperty
	property p_drv;
		ok && $past(acc, 3) && $past(ram_inhibit_line_n, 3) |-> mem_bus_oe_n == $past(chip_data_out, 3);
	endproperty
	property p_bus; ok |-> mem_bus_out == '0; endproperty
	a_acc: assert property (p_acc) else $error("bank access");
	a_rfs: assert property (p_rfs) else $error("refresh select");
	a_feed: assert property (p_feed) else $error("select feed");
	a_stb: assert property (p_stb) else $error("no strobe");
	a_inh: assert property (p_inh) else $error("inhibit");
	a_off: assert property (p_off) else $error("mismatch");
	a_din: assert property (p_din) else $error("data in map");
	a_drv: assert property (p_drv) else $error("data out");
	a_bus: assert property (p_bus) else $error("bus only discharged");
endmodule // rmbs_asserts
bind rmbs_top rmbs_asserts i_rmbs_asserts (.*);

// ===== test/rmbs_cpu_model.sv
`timescale 1ns/10ps
// processor side: precharged bus and inhibit wire
module rmbs_cpu_model (
	input  wire logic        rom_hit,
	input  wire logic [15:0] drive,
	input  wire logic [15:0] ram_oe_n,
	output logic             inhibit_n,
	output logic [15:0]      bus
);
	assign bus = drive & ram_oe_n;
	assign inhibit_n = !rom_hit;
endmodule // rmbs_cpu_model

// ===== test/test_ram_module_bank_select.sv
`timescale 1ns/10ps
module test_ram_module_bank_select;
	import rmbs_pkg::*;
	logic        clk, sys_rst, feed, astb_n, oe_n, inh_n;
	logic [15:0] bus, boe_n, cdi;
	logic [2:0]  st;
	logic [37:0] want;
	logic [63:0] r = 64'h0000_0180_0000_ffff;
	logic [31:0] seed = 32'hafc0;
	logic [63:0] corner [4] = '{64'h0000_0148_ffff_ffff, 64'h0000_0000_0000_ffff,
		64'h0000_0180_1234_ffff, 64'h0000_0100_a5a5_0000};
	int          errors = 0, checks = 0;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// expected outputs for one stimulus word
	function automatic logic [37:0] expect_of(input logic [63:0] v);
		logic acc, rf;
		logic [15:0] oe, w;
		acc = !v[39] && !v[38] && v[34:32] == v[37:35];
		rf = !v[39] && v[38];
		oe = (acc && v[40]) ? v[31:16] : 16'hffff;
		w = v[15:0] & oe;
		return {!(acc || rf), !(acc && v[40]), rf, rf ? 3'h4 : acc ? 3'h2 : 3'h1, oe, w[3:0], w[11:0]};
	endfunction
	rmbs_cpu_model i_rmbs_cpu_model (.rom_hit(!r[40]), .drive(r[15:0]), .ram_oe_n(boe_n), .inhibit_n(inh_n), .bus);
	rmbs_top i_rmbs_top (.clk, .sys_rst, .mem_bus_in(bus), .bank_address_lines(r[34:32]), .refresh_select_line(r[38]),
		.memory_cycle_strobe_n(r[39]), .ram_inhibit_line_n(inh_n), .bank_jumper_one(r[35]), .bank_jumper_two(r[36]),
		.bank_jumper_three(r[37]), .chip_data_out(r[31:16]), .chip_data_in(cdi), .refresh_chip_select_feed(feed),
		.array_strobe_n(astb_n), .ram_output_enable_n(oe_n), .mem_bus_out(), .mem_bus_oe_n(boe_n), .state_out(st));
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// corners first, then random words
	initial begin
		sys_rst = 1;
		repeat (12) @(posedge clk);
		#1 sys_rst = 0;
		for (int i = 0; i < 150; i++) begin
			seed = xs(seed);
			r[31:0] = seed;
			seed = xs(seed);
			r[63:32] = seed;
			if (r[38]) r[39] = 0;
			if (r[42]) r[37:35] = r[34:32];
			r[40] = r[40] | r[41];
			if (i < 4) r = corner[i];
			repeat (8) @(posedge clk);
			#1 want = expect_of(r);
			checks += 3;
			if ({astb_n, oe_n, feed, st} !== want[37:32]) begin
				errors++;
				$display("ERROR control expected %h seen %h", want[37:32], {astb_n, oe_n, feed, st});
			end
			if (boe_n !== want[31:16]) begin
				errors++;
				$display("ERROR mem_bus_oe_n expected %h seen %h", want[31:16], boe_n);
			end
			if (cdi !== want[15:0]) begin
				errors++;
				$display("ERROR chip_data_in expected %h seen %h", want[15:0], cdi);
			end
		end
		tally_and_finish();
	end
endmodule // test_ram_module_bank_select
